// file: design/ccsi_pkg.sv
// Constants and types shared by the communication card status indicators.
package ccsi_pkg;

  // Default system clock rate in hertz.
  localparam int CLK_HZ_DFLT = 50_000_000;
  // Base flash step: every flash half period is a whole number of steps.
  localparam int BASE_TICK_MS = 125;
  // Default prescaler length in clock cycles for one base step.
  localparam int TICK_CYC_DFLT = CLK_HZ_DFLT / 1000 * BASE_TICK_MS;
  // Prescaler counter width; holds TICK_CYC_DFLT with room to spare.
  localparam int PRESC_W = 24;

  // Half periods of the three flash rates, in milliseconds.
  localparam int HALF_1HZ_MS = 500;
  localparam int HALF_2HZ_MS = 250;
  localparam int HALF_4HZ_MS = 125;
  // The same half periods counted in base steps.
  localparam int HALF_1HZ_TICKS = HALF_1HZ_MS / BASE_TICK_MS;
  localparam int HALF_2HZ_TICKS = HALF_2HZ_MS / BASE_TICK_MS;
  localparam int HALF_4HZ_TICKS = HALF_4HZ_MS / BASE_TICK_MS;
  // Width of the step counter inside one flash generator.
  localparam int BLINK_CNT_W = 3;

  // Link state with the control board, as reported on link_state_i.
  typedef enum logic [1:0] {
    LINK_LOST,
    LINK_SETUP,
    LINK_UP
  } ccsi_link_type;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;

  // Control register fields and value after reset.
  localparam int CTRL_W = 2;
  localparam int CTRL_ETH_BIT = 0;
  localparam int CTRL_DIAG_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h2;

  // Interrupt status, enable and clear layout.
  localparam int IRQ_W = 4;
  localparam int IRQ_LOST_BIT = 0;
  localparam int IRQ_UP_BIT = 1;
  localparam int IRQ_FAULT_BIT = 2;
  localparam int IRQ_ONLINE_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

endpackage

// file: design/ccsi_blink.sv
// Flash generator: toggles a phase after a fixed number of base steps.
`timescale 1ns/100ps
`default_nettype none

module ccsi_blink #(
  parameter int HALF_TICKS = 4 // Base steps per half period.
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic tick_i, // One-cycle base step pulse.
  output logic phase_o // Flash phase, lit when high.
);

  // All state of the generator.
  typedef struct packed {
    logic [ccsi_pkg::BLINK_CNT_W-1:0] cnt; // Steps in this half period.
    logic phase; // Current phase.
  } ccsi_blink_state_type;

  localparam logic [ccsi_pkg::BLINK_CNT_W-1:0] LAST =
    ccsi_pkg::BLINK_CNT_W'(HALF_TICKS - 1);

  ccsi_blink_state_type s_r; // Registered state.
  ccsi_blink_state_type s_nxt; // Next state.

  ////////////////////////////////////////////////////////////////////////
  // Next state. Lit and dark halves use the same count, so duty is even.
  always_comb begin
    s_nxt = s_r;
    if (tick_i) begin
      if (s_r.cnt == LAST) begin
        s_nxt.cnt = '0;
        s_nxt.phase = ~s_r.phase;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign phase_o = s_r.phase;

  ////////////////////////////////////////////////////////////////////////
  // The phase only turns on a base step that closes a half period.
  a_phase_turn: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(s_r.phase) |-> $past(tick_i) && $past(s_r.cnt) == LAST)
    else $error("flash phase turned off a half period boundary");

endmodule

`default_nettype wire

// file: design/ccsi_top.sv
// Status lamp controller of a fieldbus or Ethernet expansion card.
`timescale 1ns/100ps
`default_nettype none

module ccsi_top #(
  parameter int CLK_HZ = ccsi_pkg::CLK_HZ_DFLT, // System clock in hertz.
  parameter int TICK_CYC = CLK_HZ / 1000 * ccsi_pkg::BASE_TICK_MS // Step.
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [1:0] link_state_i, // Control board link state.
  input wire logic power_i, // Control board feeds card power.
  input wire logic online_i, // Fieldbus online, data exchange possible.
  input wire logic offline_i, // Fieldbus offline, no data exchange.
  input wire logic cfg_err_i, // Configuration length mismatch.
  input wire logic prm_err_i, // Parameter length or content wrong.
  input wire logic asic_err_i, // Protocol chip initialisation failed.
  input wire logic phy_link_i, // Ethernet physical link good.
  input wire logic data_xchg_i, // Ethernet data exchange active.
  input wire logic tx_active_i, // Card is transmitting on the bus.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output logic irq_o, // Interrupt, high while enabled event is set.
  output logic link_status_lamp_o, // Control board link lamp.
  output logic online_lamp_o, // Online or network connection lamp.
  output logic offline_fault_lamp_o, // Fault or network traffic lamp.
  output logic power_lamp_o, // Power lamp.
  output logic rts_o // Request to send, high while transmitting.
);

  // All state of the controller.
  typedef struct packed {
    logic [ccsi_pkg::PRESC_W-1:0] presc; // Prescaler count.
    logic tick; // Base step pulse.
    logic [ccsi_pkg::CTRL_W-1:0] ctrl; // Control register.
    logic [ccsi_pkg::IRQ_W-1:0] irq_stat; // Sticky event bits.
    logic [ccsi_pkg::IRQ_W-1:0] irq_en; // Event enables.
    logic irq; // Interrupt output.
    logic [1:0] prev_link; // Link state one cycle ago.
    logic prev_fault; // Any error one cycle ago.
    logic prev_online; // Online one cycle ago.
    logic link_lamp; // Link lamp.
    logic online_lamp; // Online lamp.
    logic fault_lamp; // Offline or fault lamp.
    logic power_lamp; // Power lamp.
    logic rts; // Request to send.
    logic ack; // Bus acknowledge.
    logic [31:0] dat; // Bus read data.
  } ccsi_state_type;

  localparam logic [ccsi_pkg::PRESC_W-1:0] TICK_LAST =
    ccsi_pkg::PRESC_W'(TICK_CYC - 1);

  ccsi_state_type s_r; // Registered state.
  ccsi_state_type s_nxt; // Next state.
  logic ph1; // 1 Hz flash phase.
  logic ph2; // 2 Hz flash phase.
  logic ph4; // 4 Hz flash phase.

  ////////////////////////////////////////////////////////////////////////
  // Flash generators, all stepped by the same prescaler pulse so that the
  // three rates stay locked to each other.
  ccsi_blink #(.HALF_TICKS(ccsi_pkg::HALF_1HZ_TICKS)) u_blink1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(s_r.tick),
    .phase_o(ph1)
  );

  ccsi_blink #(.HALF_TICKS(ccsi_pkg::HALF_2HZ_TICKS)) u_blink2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(s_r.tick),
    .phase_o(ph2)
  );

  ccsi_blink #(.HALF_TICKS(ccsi_pkg::HALF_4HZ_TICKS)) u_blink4 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(s_r.tick),
    .phase_o(ph4)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state: prescaler, lamps, events and the register bus.
  always_comb begin
    logic req; // New bus request this cycle.
    logic any_err; // Some fault condition active.
    logic [ccsi_pkg::IRQ_W-1:0] ev; // Events seen this cycle.
    logic [ccsi_pkg::IRQ_W-1:0] clr; // Bits cleared by software.
    logic eth; // Ethernet profile selected.
    logic diag; // Diagnosis enabled.
    req = 1'b0;
    any_err = 1'b0;
    ev = '0;
    clr = '0;
    eth = s_r.ctrl[ccsi_pkg::CTRL_ETH_BIT];
    diag = s_r.ctrl[ccsi_pkg::CTRL_DIAG_BIT];
    s_nxt = s_r;

    s_nxt.tick = 1'b0;
    if (s_r.presc == TICK_LAST) begin
      s_nxt.presc = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.presc = s_r.presc + 1'b1;
    end

    s_nxt.power_lamp = power_i;

    // Link lamp; an unused code is shown as a lost link.
    // steady during setup
    if (link_state_i == ccsi_pkg::LINK_SETUP) begin
      s_nxt.link_lamp = 1'b1;
    end else if (link_state_i == ccsi_pkg::LINK_UP) begin
      s_nxt.link_lamp = ph1;
    end else begin
      s_nxt.link_lamp = 1'b0;
    end

    if (eth) begin
      s_nxt.online_lamp = phy_link_i;
      s_nxt.fault_lamp = data_xchg_i ? 1'b1 : ph1;
    end else begin
      s_nxt.online_lamp = online_i;
      if (!diag) begin
        s_nxt.fault_lamp = 1'b0;
      end else if (asic_err_i) begin
        s_nxt.fault_lamp = ph4;
      end else if (prm_err_i) begin
        s_nxt.fault_lamp = ph2;
      end else if (cfg_err_i) begin
        s_nxt.fault_lamp = ph1;
      end else if (offline_i) begin
        s_nxt.fault_lamp = 1'b1;
      end else begin
        s_nxt.fault_lamp = ph1;
      end
    end

    if (!power_i) begin
      s_nxt.link_lamp = 1'b0;
      s_nxt.online_lamp = 1'b0;
      s_nxt.fault_lamp = 1'b0;
    end

    s_nxt.rts = tx_active_i;

    // Events are edges of the condition inputs.
    any_err = asic_err_i | prm_err_i | cfg_err_i;
    s_nxt.prev_link = link_state_i;
    s_nxt.prev_fault = any_err;
    s_nxt.prev_online = online_i;
    ev[ccsi_pkg::IRQ_LOST_BIT] = (link_state_i == ccsi_pkg::LINK_LOST) &&
                                 (s_r.prev_link != ccsi_pkg::LINK_LOST);
    ev[ccsi_pkg::IRQ_UP_BIT] = (link_state_i == ccsi_pkg::LINK_UP) &&
                               (s_r.prev_link != ccsi_pkg::LINK_UP);
    ev[ccsi_pkg::IRQ_FAULT_BIT] = any_err && !s_r.prev_fault;
    ev[ccsi_pkg::IRQ_ONLINE_BIT] = online_i != s_r.prev_online;

    // Bus slave: one wait state, ack drops the cycle after it is given.
    req = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack = req;
    if (req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        ccsi_pkg::REG_CTRL: begin
          s_nxt.ctrl = wb_dat_i[ccsi_pkg::CTRL_W-1:0];
        end
        ccsi_pkg::REG_IRQ_EN: begin
          s_nxt.irq_en = wb_dat_i[ccsi_pkg::IRQ_W-1:0];
        end
        ccsi_pkg::REG_IRQ_CLR: begin
          clr = wb_dat_i[ccsi_pkg::IRQ_W-1:0];
        end
        default: begin
          // Read-only or unmapped: the write is dropped.
        end
      endcase
    end
    // A set in the same cycle as its clear wins, so no event is lost.
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);

    // Read data; unmapped and write-only offsets read as zero.
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ccsi_pkg::REG_CTRL: begin
          s_nxt.dat = {30'h0, s_r.ctrl};
        end
        ccsi_pkg::REG_STATUS: begin
          s_nxt.dat = {25'h0, s_r.rts, link_state_i, s_r.power_lamp,
                       s_r.fault_lamp, s_r.online_lamp, s_r.link_lamp};
        end
        ccsi_pkg::REG_IRQ_STAT: begin
          s_nxt.dat = {28'h0, s_r.irq_stat};
        end
        ccsi_pkg::REG_IRQ_EN: begin
          s_nxt.dat = {28'h0, s_r.irq_en};
        end
        default: begin
          s_nxt.dat = 32'h0;
        end
      endcase
    end else begin
      s_nxt.dat = 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; control takes its reset values here.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ctrl <= ccsi_pkg::CTRL_RST;
      s_r.irq_en <= ccsi_pkg::IRQ_EN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops.
  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign irq_o = s_r.irq;
  assign link_status_lamp_o = s_r.link_lamp;
  assign online_lamp_o = s_r.online_lamp;
  assign offline_fault_lamp_o = s_r.fault_lamp;
  assign power_lamp_o = s_r.power_lamp;
  assign rts_o = s_r.rts;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the lamp outputs, rts_o, the base step and the bus ack, one cycle behind their causes.
  a_link_setup_on: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && link_state_i == ccsi_pkg::LINK_SETUP |=> link_status_lamp_o)
    else $error("link lamp not steady during setup");

  a_link_up_flash: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && link_state_i == ccsi_pkg::LINK_UP
    |=> link_status_lamp_o == $past(ph1))
    else $error("link lamp not on the one second flash");

  a_link_lost_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    link_state_i == ccsi_pkg::LINK_LOST |=> !link_status_lamp_o)
    else $error("link lamp lit with link lost");

  a_online_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && !s_r.ctrl[ccsi_pkg::CTRL_ETH_BIT]
    |=> online_lamp_o == $past(online_i))
    else $error("online lamp does not follow online state");

  a_offline_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && s_r.ctrl == ccsi_pkg::CTRL_RST && offline_i &&
    !asic_err_i && !prm_err_i && !cfg_err_i |=> offline_fault_lamp_o)
    else $error("fault lamp not steady while offline");

  a_not_offline: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && s_r.ctrl == ccsi_pkg::CTRL_RST && !offline_i &&
    !asic_err_i && !prm_err_i && !cfg_err_i
    |=> offline_fault_lamp_o == $past(ph1))
    else $error("fault lamp not flashing when not offline");

  a_cfg_one_hz: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && s_r.ctrl == ccsi_pkg::CTRL_RST && cfg_err_i &&
    !asic_err_i && !prm_err_i |=> offline_fault_lamp_o == $past(ph1))
    else $error("configuration error not shown at 1 Hz");

  a_prm_two_hz: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && s_r.ctrl == ccsi_pkg::CTRL_RST && prm_err_i && !asic_err_i
    |=> offline_fault_lamp_o == $past(ph2))
    else $error("parameter error not shown at 2 Hz");

  a_asic_four_hz: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && s_r.ctrl == ccsi_pkg::CTRL_RST && asic_err_i
    |=> offline_fault_lamp_o == $past(ph4))
    else $error("chip init error not shown at 4 Hz");

  a_diag_off_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.ctrl == 2'h0 |=> !offline_fault_lamp_o)
    else $error("fault lamp lit with diagnosis disabled");

  a_power_lamp: assert property (@(posedge clk_i) disable iff (rst_i)
    !power_i |=> !power_lamp_o && !link_status_lamp_o && !online_lamp_o)
    else $error("lamp lit without card power");

  a_eth_connect: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && s_r.ctrl[ccsi_pkg::CTRL_ETH_BIT]
    |=> online_lamp_o == $past(phy_link_i))
    else $error("connection lamp does not follow physical link");

  a_eth_traffic: assert property (@(posedge clk_i) disable iff (rst_i)
    power_i && s_r.ctrl[ccsi_pkg::CTRL_ETH_BIT] && !data_xchg_i
    |=> offline_fault_lamp_o == $past(ph1))
    else $error("traffic lamp not flashing when idle");

  a_rts_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 rts_o == $past(tx_active_i))
    else $error("request to send does not follow transmit");

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.tick |=> !s_r.tick)
    else $error("base step pulse longer than one cycle");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held two cycles");

endmodule

`default_nettype wire

// file: dv/ccsi_board_model.sv
// Behavioural model of the control board and fieldbus logic feeding the card.
`timescale 1ns/100ps
`default_nettype none

module ccsi_board_model (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [10:0] cond_i, // Requested condition set from the bench.
  output logic [1:0] link_state_o, // Link state towards the card.
  output logic power_o, // Card power feed.
  output logic online_o, // Fieldbus online.
  output logic offline_o, // Fieldbus offline.
  output logic cfg_err_o, // Configuration length error.
  output logic prm_err_o, // Parameter data error.
  output logic asic_err_o, // Protocol chip start-up error.
  output logic phy_link_o, // Ethernet physical link.
  output logic data_xchg_o, // Ethernet data exchange.
  output logic tx_active_o // Card transmitting.
);
  //////////////////////////////////////////////////////////////////////////
  // The board changes its levels only on a clock edge, as real logic would.
  // Reset drops everything, so power is off until the bench asks for it.
  // power fed on the same edge as every other level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {tx_active_o, data_xchg_o, phy_link_o, asic_err_o} <= 4'h0;
      {prm_err_o, cfg_err_o, offline_o, online_o} <= 4'h0;
      {power_o, link_state_o} <= 3'h0;
    end else begin
      {tx_active_o, data_xchg_o, phy_link_o, asic_err_o} <= cond_i[10:7];
      {prm_err_o, cfg_err_o, offline_o, online_o} <= cond_i[6:3];
      {power_o, link_state_o} <= cond_i[2:0];
    end
  end
endmodule
`default_nettype wire

// file: dv/ccsi_top_test.sv
// Self-checking testbench of the status lamp controller.
`timescale 1ns/100ps
`default_nettype none

module ccsi_top_test;
  localparam int TICK = 4; // Short base step keeps flash periods brief.
  logic clk_i = 1'b0; // System clock.
  logic rst_i = 1'b1; // Reset, held at start.
  logic [10:0] cond = 11'h000; // Condition request to the board model.
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0; // Bus request.
  logic [7:0] wb_adr = 8'h00; // Bus address.
  logic [31:0] wb_wdat = 32'h0; // Bus write data.
  logic [31:0] wb_rdat, q; // Read data and last read result.
  logic wb_ack, irq, rts, lnk, onl, flt, pwr; // Design outputs.
  logic [1:0] ls; // Link state wire.
  logic pw, on, off, ce, pe, ae, phy, dx, tx; // Condition wires.
  wire logic [3:0] lamps = {pwr, flt, onl, lnk}; // Lamps by index.
  int error_cnt = 0; // Mismatches seen.
  int num_checks = 0; // Comparisons made.

  // Half period of 10 ns gives the 50 MHz system clock.
  always #10 clk_i = ~clk_i;

  ccsi_board_model board_u (.clk_i(clk_i), .rst_i(rst_i), .cond_i(cond),
    .link_state_o(ls), .power_o(pw), .online_o(on), .offline_o(off),
    .cfg_err_o(ce), .prm_err_o(pe), .asic_err_o(ae), .phy_link_o(phy),
    .data_xchg_o(dx), .tx_active_o(tx));

  ccsi_top #(.TICK_CYC(TICK)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .link_state_i(ls), .power_i(pw), .online_i(on), .offline_i(off),
    .cfg_err_i(ce), .prm_err_i(pe), .asic_err_i(ae), .phy_link_i(phy),
    .data_xchg_i(dx), .tx_active_i(tx), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .irq_o(irq), .link_status_lamp_o(lnk),
    .online_lamp_o(onl), .offline_fault_lamp_o(flt), .power_lamp_o(pwr),
    .rts_o(rts));

  //////////////////////////////////////////////////////////////////////////
  // Prints the verdict once and ends the run.
  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Moves just past the next edge, where outputs have settled.
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // One classic Wishbone cycle; the wait for ack is bounded.
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= {2'b11, we};
    wb_adr <= adr;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack !== 1'b1 && t < 50);
    q = wb_rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    if (t >= 50) begin
      error_cnt++;
      test_done();
    end
  endtask

  // Applies a condition set and lets it pass the model and the lamp flops.
  task automatic set(input logic [10:0] v);
    @(posedge clk_i);
    cond <= v;
    repeat (3) step();
  endtask

  // Checks that one lamp keeps a level for n cycles; a flash would break it.
  task automatic hold_chk(input int idx, input logic exp, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      step();
      if (lamps[idx] !== exp) bad++;
    end
    chk("lamp level misses", 32'h0, 32'(bad));
  endtask

  // Measures the lit half of one flash of a lamp in clock cycles.
  task automatic half_chk(input int idx, input int exp);
    int n;
    int t;
    n = 0;
    t = 0;
    while (lamps[idx] !== 1'b0 && t < 300) begin step(); t++; end
    while (lamps[idx] !== 1'b1 && t < 300) begin step(); t++; end
    while (lamps[idx] === 1'b1 && t < 300) begin n++; step(); t++; end
    if (t >= 300) begin
      error_cnt++;
      test_done();
    end else begin
      chk("lamp lit cycles", 32'(exp), 32'(n));
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence; flash halves are 4, 2 and 1 base steps of TICK cycles.
  logic [10:0] fc [5] = '{11'h004, 11'h024, 11'h044, 11'h084, 11'h0F4};
  int fh [5] = '{4 * TICK, 4 * TICK, 2 * TICK, TICK, TICK};
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    step();
    wb(1'b0, ccsi_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", 32'(ccsi_pkg::CTRL_RST), q);
    wb(1'b0, ccsi_pkg::REG_IRQ_EN, 32'h0);
    chk("irq enable reset", 32'h0, q);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, q);
    set(11'h019);
    chk("lamps without power", 32'h0, 32'(lamps));
    set(11'h005);
    hold_chk(3, 1'b1, 5);
    hold_chk(0, 1'b1, 40);
    set(11'h006);
    half_chk(0, 4 * TICK);
    set(11'h004);
    hold_chk(0, 1'b0, 40);
    // The spare link code must also read as a lost link.
    set(11'h007);
    hold_chk(0, 1'b0, 10);
    set(11'h00C);
    hold_chk(1, 1'b1, 10);
    set(11'h004);
    hold_chk(1, 1'b0, 10);
    set(11'h014);
    hold_chk(2, 1'b1, 40);
    // Status word: power and fault lamps lit, link lost, not sending.
    wb(1'b0, ccsi_pkg::REG_STATUS, 32'h0);
    chk("status word", 32'h0000000C, q);
    // Not offline, cfg, prm, asic, then all errors at once.
    for (int i = 0; i < 5; i++) begin
      set(fc[i]);
      half_chk(2, fh[i]);
    end
    set(11'h064);
    half_chk(2, 2 * TICK);
    wb(1'b1, ccsi_pkg::REG_CTRL, 32'h0);
    set(11'h094);
    hold_chk(2, 1'b0, 40);
    wb(1'b1, ccsi_pkg::REG_CTRL, 32'h3);
    set(11'h104);
    hold_chk(1, 1'b1, 10);
    set(11'h204);
    hold_chk(1, 1'b0, 10);
    hold_chk(2, 1'b1, 40);
    set(11'h004);
    half_chk(2, 4 * TICK);
    set(11'h404);
    chk("rts sending", 32'h1, 32'(rts));
    set(11'h004);
    chk("rts receiving", 32'h0, 32'(rts));
    // Interrupt: masked event, then enabled, then cleared.
    wb(1'b1, ccsi_pkg::REG_IRQ_CLR, 32'hF);
    set(11'h006);
    set(11'h004);
    chk("irq masked", 32'h0, 32'(irq));
    wb(1'b0, ccsi_pkg::REG_IRQ_STAT, 32'h0);
    chk("lost event", 32'h1, q & 32'h1);
    wb(1'b1, ccsi_pkg::REG_IRQ_EN, 32'h1);
    repeat (2) step();
    chk("irq raised", 32'h1, 32'(irq));
    wb(1'b1, ccsi_pkg::REG_IRQ_CLR, 32'h1);
    repeat (2) step();
    chk("irq cleared", 32'h0, 32'(irq));
    wb(1'b0, ccsi_pkg::REG_IRQ_STAT, 32'h0);
    chk("lost event cleared", 32'h0, q & 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
